// ### inc/hb_pkg.sv
// constants for the half-bridge mode and pwm allocation register bank
// Behaviour
// - blank code selects 625ns up to 16us
// - mode 00 off, 01 low on, 10 high on
// - reserved mode 11 behaves as off
// - four mode fields, reset all off
// - reserved read-only bits return zero
// - routing register reachable only in bank zero
// - channel three bridge select, reset 010
// - channel two bridge select, reset 001
// - channel enables bits 8 and 4, reset off
// - writable reserved bits reset to 110
// - channel one select bits 3:1, enable bit 0
// - double allocation flags error, bridge off
package hb_pkg;
  localparam int          NUM_BRIDGES   = 4;
  localparam int          NUM_CHANNELS  = 3;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 16;
  localparam int          BANK_W        = 3;
  localparam int          CODE_W        = 3;
  localparam int          CNT_W         = 9;
  // register offsets
  localparam logic [4:0]  OFS_STATIC    = 5'h06;
  localparam logic [4:0]  OFS_ROUTING   = 5'h07;
  localparam logic [2:0]  BANK_ROUTING  = 3'h0;
  // reset values
  localparam logic [15:0] RST_STATIC    = 16'h0000;
  localparam logic [15:0] RST_ROUTING   = 16'h6420;
  // writable bit masks, everything else reads zero
  localparam logic [15:0] MASK_STATIC   = 16'h00ff;
  localparam logic [15:0] MASK_ROUTING  = 16'h7fff;
  // static mode field encodings
  localparam int          MODE_W        = 2;
  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [1:0]  MODE_LOW      = 2'h1;
  localparam logic [1:0]  MODE_HIGH     = 2'h2;
  // routing field layout
  localparam int          CH1_EN_BIT    = 0;
  localparam int          CH1_SEL_LSB   = 1;
  localparam int          CH2_EN_BIT    = 4;
  localparam int          CH2_SEL_LSB   = 5;
  localparam int          CH3_EN_BIT    = 8;
  localparam int          CH3_SEL_LSB   = 9;
  // freewheel blanking
  localparam logic [2:0]  BLANK_DEFAULT = 3'h4;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          BLANK_0_NS    = 625;
  localparam int          BLANK_1_NS    = 1000;
  localparam int          BLANK_2_NS    = 1250;
  localparam int          BLANK_3_NS    = 1500;
  localparam int          BLANK_4_NS    = 2000;
  localparam int          BLANK_5_NS    = 3000;
  localparam int          BLANK_6_NS    = 4000;
  localparam int          BLANK_7_NS    = 16000;

  // least time: round up to whole clock cycles
  function automatic logic [8:0] ns_to_cycles(input int ns);
    ns_to_cycles = 9'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : ns_to_cycles

  // pwm bridge selection: 1xx folds back, 111 lands on bridge three
  function automatic logic [1:0] bridge_of(input logic [2:0] code);
    if (code == 3'h7) begin
      bridge_of = 2'h2;
    end else begin
      bridge_of = code[1:0];
    end
  endfunction : bridge_of
endpackage : hb_pkg

// ### hdl/bridge_drive.sv
// gate control of one half-bridge: static mode or pwm follower
`timescale 1ns/10ps
module bridge_drive (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic [1:0] mode_field,
  input  wire logic       pwm_owned,
  input  wire logic       pwm_level,
  input  wire logic       conflict,
  // gate requests
  output logic            high_on_q,
  output logic            low_on_q
);
  logic high_d;
  logic low_d;

  // select gate state; a conflict wins over everything
  always_comb begin
    high_d = 1'b0;
    low_d  = 1'b0;
    if (conflict) begin
      high_d = 1'b0;
      low_d  = 1'b0;
    end else if (pwm_owned) begin
      high_d = pwm_level;
      low_d  = ~pwm_level;
    end else begin
      case (mode_field)
        hb_pkg::MODE_LOW:  low_d  = 1'b1;
        hb_pkg::MODE_HIGH: high_d = 1'b1;
        default: begin
          high_d = 1'b0;
          low_d  = 1'b0;
        end
      endcase
    end
  end

  // registered so both gates never glitch on together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_on_q <= 1'b0;
      low_on_q  <= 1'b0;
    end else begin
      high_on_q <= high_d;
      low_on_q  <= low_d;
    end
  end
endmodule : bridge_drive

// ### hdl/bridge_ctrl_top.sv
// half-bridge static mode and pwm channel allocation register bank
`timescale 1ns/10ps
module bridge_ctrl_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // register access from the serial front end
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [2:0]  reg_bank,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata_q,
  output logic             reg_rvalid_q,
  // pwm input pins, channel one in bit 0
  input  wire logic [2:0]  pwm_in,
  // freewheel blanking codes, bridge one in bits 2:0
  input  wire logic [11:0] freewheel_blanking_code,
  output logic [35:0]      blank_cycles_q,
  // status
  output logic             alloc_error_q,
  // gate requests, bridge one in bit 0
  output logic [3:0]       high_switch,
  output logic [3:0]       low_switch
);
  logic        rst_meta_q;
  logic        rst_n;
  logic [2:0]  pwm_meta_q;
  logic [2:0]  pwm_sync_q;
  logic [15:0] static_q;
  logic [15:0] routing_q;
  logic        routing_hit;
  logic        static_hit;
  logic [2:0]  chan_en;
  logic [1:0]  chan_br [3];
  logic [3:0]  owned;
  logic [3:0]  conflict;
  logic [3:0]  pwm_level;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // pwm pins are asynchronous: two-flop synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_meta_q <= 3'h0;
      pwm_sync_q <= 3'h0;
    end else begin
      pwm_meta_q <= pwm_in;
      pwm_sync_q <= pwm_meta_q;
    end
  end

  // address decode; static mode is not banked
  assign static_hit  = (reg_addr == hb_pkg::OFS_STATIC);
  assign routing_hit = (reg_addr == hb_pkg::OFS_ROUTING) &&
                       (reg_bank == hb_pkg::BANK_ROUTING);

  // static mode register, reserved upper byte never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      static_q <= hb_pkg::RST_STATIC;
    end else if (reg_wr && static_hit) begin
      static_q <= reg_wdata & hb_pkg::MASK_STATIC;
    end
  end

  // routing register, reserved bits 14:12 writable, bit 15 dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      routing_q <= hb_pkg::RST_ROUTING;
    end else if (reg_wr && routing_hit) begin
      routing_q <= reg_wdata & hb_pkg::MASK_ROUTING;
    end
  end

  // read port: one cycle latency, unmapped or wrong bank reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q  <= 16'h0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        if (static_hit) begin
          reg_rdata_q <= static_q;
        end else if (routing_hit) begin
          reg_rdata_q <= routing_q;
        end else begin
          reg_rdata_q <= 16'h0000;
        end
      end
    end
  end

  // field extraction
  assign chan_en[0] = routing_q[hb_pkg::CH1_EN_BIT];
  assign chan_en[1] = routing_q[hb_pkg::CH2_EN_BIT];
  assign chan_en[2] = routing_q[hb_pkg::CH3_EN_BIT];
  assign chan_br[0] = hb_pkg::bridge_of(
    routing_q[hb_pkg::CH1_SEL_LSB +: hb_pkg::CODE_W]);
  assign chan_br[1] = hb_pkg::bridge_of(
    routing_q[hb_pkg::CH2_SEL_LSB +: hb_pkg::CODE_W]);
  assign chan_br[2] = hb_pkg::bridge_of(
    routing_q[hb_pkg::CH3_SEL_LSB +: hb_pkg::CODE_W]);

  // per bridge: count enabled channels that claim it
  always_comb begin
    int hits;
    hits = 0;
    owned     = 4'h0;
    conflict  = 4'h0;
    pwm_level = 4'h0;
    for (int b = 0; b < hb_pkg::NUM_BRIDGES; b++) begin
      hits = 0;
      for (int c = 0; c < hb_pkg::NUM_CHANNELS; c++) begin
        if (chan_en[c] && (chan_br[c] == 2'(b))) begin
          hits++;
          pwm_level[b] = pwm_sync_q[c];
        end
      end
      owned[b]    = (hits == 1);
      conflict[b] = (hits > 1);
    end
  end

  // error flag follows the allocation while it is inconsistent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alloc_error_q <= 1'b0;
    end else begin
      alloc_error_q <= |conflict;
    end
  end

  // freewheel blanking code to cycle count, rounded up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < hb_pkg::NUM_BRIDGES; b++) begin
        blank_cycles_q[b*hb_pkg::CNT_W +: hb_pkg::CNT_W] <=
          hb_pkg::ns_to_cycles(hb_pkg::BLANK_4_NS);
      end
    end else begin
      for (int b = 0; b < hb_pkg::NUM_BRIDGES; b++) begin
        case (freewheel_blanking_code[b*hb_pkg::CODE_W +: hb_pkg::CODE_W])
          3'h0: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_0_NS);
          3'h1: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_1_NS);
          3'h2: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_2_NS);
          3'h3: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_3_NS);
          3'h5: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_5_NS);
          3'h6: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_6_NS);
          // longest blanking: host must cap gate current itself
          3'h7: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_7_NS);
          default: blank_cycles_q[b*9 +: 9] <=
                  hb_pkg::ns_to_cycles(hb_pkg::BLANK_4_NS);
        endcase
      end
    end
  end

  // one gate controller per half-bridge
  for (genvar b = 0; b < hb_pkg::NUM_BRIDGES; b++) begin : g_bridge
    bridge_drive u_drive (
      .clk        (clk),
      .rst_n      (rst_n),
      .mode_field (static_q[b*hb_pkg::MODE_W +: hb_pkg::MODE_W]),
      .pwm_owned  (owned[b]),
      .pwm_level  (pwm_level[b]),
      .conflict   (conflict[b]),
      .high_on_q  (high_switch[b]),
      .low_on_q   (low_switch[b])
    );
  end : g_bridge
endmodule : bridge_ctrl_top

// ### tb/host_model.sv
// host model driving the register strobes of the bridge bank
`timescale 1ns/10ps
module host_model (
  // clock and answer
  input  wire logic        clk,
  input  wire logic        rvalid,
  input  wire logic [15:0] rdata,
  // request
  output logic             wr,
  output logic             rd,
  output logic [4:0]       addr,
  output logic [2:0]       bank,
  output logic [15:0]      wdata
);
  initial {wr, rd, addr, bank, wdata} = '0;
  // one request per call; released lines show inverted junk, not a hold
  task automatic acc(input logic w, input logic [2:0] b,
      input logic [4:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic ok);
    @(negedge clk);
    {wr, rd, bank, addr, wdata} = {w, !w, b, a, d};
    @(negedge clk);
    {wr, rd, bank, addr, wdata} = {2'b00, ~b, ~a, ~d};
    ok = w || rvalid === 1'b1;
    q = rdata;
  endtask : acc
endmodule : host_model

// ### tb/bridge_ctrl_top_chk.sv
// assertions on the bridge control bank ports
`timescale 1ns/10ps
module bridge_ctrl_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // register access
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [4:0]  reg_addr,
  input wire logic [2:0]  reg_bank,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  // blanking code input and outputs
  input wire logic [11:0] freewheel_blanking_code,
  input wire logic [35:0] blank_cycles_q,
  input wire logic        alloc_error_q,
  input wire logic [3:0]  high_switch,
  input wire logic [3:0]  low_switch
);
  logic [2:0] en_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // enable shadow: static checks only hold while no channel owns a bridge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 3'h0;
    end else if (reg_wr && reg_addr == 5'h07 && reg_bank == 3'h0) begin
      en_q <= {reg_wdata[8], reg_wdata[4], reg_wdata[0]};
    end
  end
  a_bank_hides_route:
    assert property (reg_rd && reg_addr == 5'h07 && reg_bank != 3'h0
      |=> reg_rdata_q == 16'h0) else $error("route read off bank");
  a_static_top_zero:
    assert property (reg_rd && reg_addr == 5'h06
      |=> reg_rdata_q[15:8] == 8'h0) else $error("static top set");
  a_route_top_zero:
    assert property (reg_rd && reg_addr == 5'h07
      |=> !reg_rdata_q[15]) else $error("route bit 15 set");
  a_mode_low_on:
    assert property (reg_wr && reg_addr == 5'h06 && reg_wdata[1:0] == 2'h1
      && en_q == 3'h0 |-> ##2 low_switch[0] && !high_switch[0])
      else $error("low mode lost");
  a_mode_high_on:
    assert property (reg_wr && reg_addr == 5'h06 && reg_wdata[3:2] == 2'h2
      && en_q == 3'h0 |-> ##2 high_switch[1] && !low_switch[1])
      else $error("high mode lost");
  a_mode_rsvd_off:
    assert property (reg_wr && reg_addr == 5'h06 && reg_wdata[7:6] == 2'h3
      && en_q == 3'h0 |-> ##2 !high_switch[3] && !low_switch[3])
      else $error("reserved mode drives");
  a_no_shoot:
    assert property ((high_switch & low_switch) == 4'h0)
      else $error("both switches on");
  a_err_needs_two:
    assert property ((en_q == 3'h0) [*3] |-> !alloc_error_q)
      else $error("error with no channel");
  a_blank_long:
    assert property (nrst [*3] ##0 freewheel_blanking_code[2:0] == 3'h7
      |=> blank_cycles_q[8:0] == 9'h190) else $error("long blank wrong");
endmodule : bridge_ctrl_chk

bind bridge_ctrl_top bridge_ctrl_chk bridge_ctrl_chk_i (
  .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_bank(reg_bank), .reg_wdata(reg_wdata),
  .reg_rdata_q(reg_rdata_q),
  .freewheel_blanking_code(freewheel_blanking_code),
  .blank_cycles_q(blank_cycles_q), .alloc_error_q(alloc_error_q),
  .high_switch(high_switch), .low_switch(low_switch)
);

// ### tb/test_half_bridge_mode_pwm_alloc.sv
// self-checking bench for the bridge mode and pwm allocation bank
`timescale 1ns/10ps
module test_half_bridge_mode_pwm_alloc;
  logic        clk, nrst, wr, rd, rv, err, ok;
  logic [4:0]  ad, a;
  logic [2:0]  bk, b, pwm;
  logic [11:0] fb;
  logic [15:0] wd, rq, d, q;
  logic [35:0] blk;
  logic [3:0]  hs, ls;
  logic [31:0] r;
  int          st, rt, fail_count, tests_run;
  int          ns [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

  bridge_ctrl_top bridge_ctrl_top_i (.clk(clk), .nrst(nrst), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(ad), .reg_bank(bk), .reg_wdata(wd),
    .reg_rdata_q(rq), .reg_rvalid_q(rv), .pwm_in(pwm),
    .freewheel_blanking_code(fb), .blank_cycles_q(blk),
    .alloc_error_q(err), .high_switch(hs), .low_switch(ls));
  host_model host_model_i (.clk(clk), .rvalid(rv), .rdata(rq), .wr(wr),
    .rd(rd), .addr(ad), .bank(bk), .wdata(wd));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // one step of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp

  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // read through the host; a missing answer ends the run
  task automatic rd_chk(input logic [2:0] bb, input logic [4:0] aa);
    host_model_i.acc(1'b0, bb, aa, 16'h0, q, ok);
    cmp(ok, 1'b1);
    if (!ok) close_out;
    cmp(q, aa == 5'h06 ? st : aa == 5'h07 && bb == 3'h0 ? rt : 0);
  endtask : rd_chk

  // model: owner count per bridge decides pwm, static or forced off
  task automatic chk_out;
    logic [3:0]  h, l;
    logic [35:0] y;
    logic [2:0]  c;
    logic        e;
    int          n [4];
    int          o [4];
    e = 1'b0;
    n = '{0, 0, 0, 0};
    o = '{0, 0, 0, 0};
    for (int k = 0; k < 3; k++) begin
      c = 3'(rt >> (4 * k + 1));
      if (rt[4 * k]) begin
        n[c == 3'h7 ? 2 : c[1:0]]++;
        o[c == 3'h7 ? 2 : c[1:0]] = k;
      end
    end
    for (int j = 0; j < 4; j++) begin
      c = 3'(st >> (2 * j));
      h[j] = n[j] == 1 ? pwm[o[j]] : n[j] == 0 && c[1:0] == 2'h2;
      l[j] = n[j] == 1 ? !pwm[o[j]] : n[j] == 0 && c[1:0] == 2'h1;
      e |= n[j] > 1;
      y[9 * j +: 9] = 9'((ns[fb[3 * j +: 3]] + 39) / 40);
    end
    cmp(hs, h);
    cmp(ls, l);
    cmp(err, e);
    cmp(blk, y);
  endtask : chk_out

  // reset, reset values, then random traffic with pwm and blanking codes
  initial begin
    {nrst, pwm, fb, st, fail_count, tests_run} = '0;
    rt = 'h6420;
    r = 32'h635f;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rd_chk(3'h0, 5'h06);
    rd_chk(3'h0, 5'h07);
    chk_out;
    for (int i = 0; i < 80; i++) begin
      r = lfsr(r);
      a = r[1:0] == 2'h0 ? r[12:8] : {4'h3, r[2]};
      b = r[5:4] == 2'h0 ? r[8:6] : 3'h0;
      d = a == 5'h07 ? {r[31], 3'h6, r[27:16]} : r[31:16];
      host_model_i.acc(1'b1, b, a, d, q, ok);
      if (a == 5'h06) st = d & 'hff;
      if (a == 5'h07 && b == 3'h0) rt = d & 'h7fff;
      pwm = r[15:13];
      fb = {r[24:16], 3'(i)};
      repeat (4) @(negedge clk);
      chk_out;
      rd_chk(r[10:8], a);
    end
    close_out;
  end
endmodule : test_half_bridge_mode_pwm_alloc
